// ---- core/motion_cmd_defines.svh ----
// constants of the command responder: codes, lengths, offsets, timing
`ifndef MOTION_CMD_DEFINES_SVH
`define MOTION_CMD_DEFINES_SVH
`define CODE_ERR_CMD    32'h63727265
`define CODE_ERR_DATA   32'h64727265
`define CODE_ERR_VALUE  32'h76727265
`define CODE_READ_ACC   32'h63636167
`define CODE_READ_BRK   32'h6B726267
`define CODE_READ_CAL   32'h6C616367
`define CODE_WRITE_BRK  32'h6B726273
`define LEN_ZERO        8'h01
`define LEN_CODE        8'h04
`define LEN_ACC         8'h72
`define LEN_BRK         8'h19
`define LEN_CAL         8'h76
`define ACC_BYTES       8'h6C
`define BRK_CFG_BYTES   8'h09
`define CAL_COEF_BYTES  8'h18
`define WBRK_LAST       8'h14
`define WBRK_DATA_BYTES 8'h13
`define CRC_INIT        16'hFFFF
`define CRC_POLY        16'hA001
`define BRK_FLAGS_MASK  8'h03
`define BRK_ENABLE_BIT  0
`define BRK_CUTS_BIT    1
`define BRK_MAX_DELAY   16'h2710
`define ACC_BRAKE_OFS   36
`define ACC_THERM_OFS   76
`define ACC_SWITCH_OFS  80
`define BRAKE_PRESENT_MASK 8'h01
`define BRAKE_HOLD_MASK    8'h02
`define THERM_TYPE_MASK    8'h07
`define THERM_PRESENT_MASK 8'h08
`define SWITCH_FLAGS_MASK  8'h1F
`define REG_STATUS      8'h00
`define REG_BRK_T12     8'h04
`define REG_BRK_T34     8'h08
`define REG_BRK_FLAGS   8'h0C
`define REG_ACC_INDEX   8'h10
`define REG_ACC_DATA    8'h14
`define REG_CAL0        8'h18
`define REG_CAL5        8'h2C
`define REG_CUR0        8'h30
`define REG_CUR2        8'h38
`define REG_ACC_SUMMARY 8'h3C
`define CLK_PERIOD_NS   10
`define MS_IN_NS        1000000
`define CYCLES_PER_MS_DFLT (`MS_IN_NS / `CLK_PERIOD_NS)
`define RX_TIMEOUT_MS   10
`endif

// ---- core/motion_cmd_pkg.sv ----
// types of the command responder
`default_nettype none
package motion_cmd_pkg;
  typedef enum logic [3:0] {
    REP_ZERO, REP_ERRC, REP_ERRD, REP_ERRV, REP_ECHO, REP_ACC, REP_BRK, REP_CAL
  } reply_e;
  typedef enum logic [1:0] {RX_CMD, RX_DATA, RX_REPLY} rx_e;
  typedef enum logic [2:0] {
    BR_OFF, BR_PWR_WAIT, BR_REL_WAIT, BR_READY, BR_STOP_WAIT, BR_ENG_WAIT, BR_HELD
  } brake_e;
  typedef struct packed {
    logic [7:0]  flags;
    logic [15:0] t4;
    logic [15:0] t3;
    logic [15:0] t2;
    logic [15:0] t1;
  } brake_cfg_s;
  typedef struct packed {
    logic value_err;
    logic data_err;
    logic cmd_err;
  } err_s;
endpackage : motion_cmd_pkg
`default_nettype wire

// ---- core/motion_cmd_responder.sv ----
// command responder: byte link commands, brake sequencer, calibration, apb registers
//
// Contract
// - unknown or unprocessable command code gets the command-error reply
// - data checksum mismatch gets the data-error reply
// - out-of-range command value gets the value-error reply
// - out-of-range value is replaced by a truncated substitute
// - each error reply sets its own sticky status flag
// - accessory read: four-byte request, 114-byte answer
// - accessory answer comes from the nonvolatile accessory store
// - brake accessory word: 0x1 present, 0x2 holds when powered
// - thermal sensor word: 0x7 type field, 0x8 present
// - end switch word: presence, low-active polarity, joined flags
// - brake read: four-byte request, 25-byte answer ending in checksum
// - power-up waits first delay after power on before brake release
// - after release wait second delay; motion held until then
// - stop waits third delay, engage, fourth delay, then power off; the code powers off only with flag 0x2 set and otherwise holds powered
// - brake flag 0x1 enables control, 0x2 makes engage cut power
// - calibration read: four-byte request, 118-byte answer
// - current equals slope times converter code plus offset
// - three coefficient pairs then 88 reserved bytes
// - checksum over data only, init 0xffff, reflected poly 0xa001
// - zero first byte gets a single zero byte reply
// - inter-byte timeout discards the partial command
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "motion_cmd_defines.svh"
module motion_cmd_responder #(
  parameter int CYCLES_PER_MS     = `CYCLES_PER_MS_DFLT,
  parameter int RX_TIMEOUT_CYCLES = `RX_TIMEOUT_MS * `CYCLES_PER_MS_DFLT
) (
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // byte link receive
  input  wire logic        RX_VALID_I,
  input  wire logic [7:0]  RX_DATA_I,
  output logic             RX_READY_O,
  // byte link transmit
  output logic             TX_VALID_O,
  output logic      [7:0]  TX_DATA_O,
  input  wire logic        TX_READY_I,
  // motor and brake
  input  wire logic        RUN_REQ_I,
  input  wire logic        MOVE_REQ_I,
  output logic             MOVE_GO_O,
  output logic             MOVE_READY_O,
  output logic             MOTOR_POWER_O,
  output logic             BRAKE_ENGAGE_O,
  // converter codes
  input  wire logic [15:0] ADC_WIND1_I,
  input  wire logic [15:0] ADC_WIND2_I,
  input  wire logic [15:0] ADC_TOTAL_I
);
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int j = 0; j < 8; j++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  logic [7:0]  acc_mem [0:`ACC_BYTES-1];
  logic [6:0]  acc_index;
  logic [31:0] cal_word [0:5];
  logic [31:0] cur_ma [0:2];
  logic [15:0] adc [0:2];
  motion_cmd_pkg::brake_cfg_s brake_cfg;
  motion_cmd_pkg::brake_cfg_s link_cfg;
  motion_cmd_pkg::brake_cfg_s fixed_cfg;
  motion_cmd_pkg::err_s       err_flags;
  motion_cmd_pkg::err_s       err_set;
  motion_cmd_pkg::rx_e        rx_state;
  motion_cmd_pkg::reply_e     rep_kind;
  motion_cmd_pkg::brake_e     br_state;
  logic        link_apply;
  logic        rep_go;
  logic [7:0]  rx_cnt;
  logic [31:0] cmd_word;
  logic [31:0] full_word;
  logic [7:0]  wbuf [0:`WBRK_LAST];
  logic [15:0] rx_crc;
  logic [31:0] idle_cnt;
  logic        value_bad;
  logic        rx_take;
  logic        tx_busy;
  logic        tx_done;
  logic        tx_step;
  logic [7:0]  tx_idx;
  logic [15:0] tx_crc;
  logic [7:0]  rep_len;
  logic [31:0] rep_word;
  logic [7:0]  next_byte;
  logic        next_is_data;
  logic [7:0]  d_idx;
  logic [191:0] cal_flat;
  logic        apb_wr;
  logic        apb_rd_ok;
  logic [31:0] rd_val;
  logic [31:0] acc_summary;
  logic [31:0] pre_cnt;
  logic [15:0] ms_cnt;
  logic [15:0] wait_ms;
  logic        expired;
  logic        brk_en;

  // converter-to-milliamp path, slope in 16.16 fixed point
  assign adc[0] = ADC_WIND1_I;
  assign adc[1] = ADC_WIND2_I;
  assign adc[2] = ADC_TOTAL_I;
  for (genvar g = 0; g < 3; g++) begin : g_cur
    logic signed [48:0] prod;
    assign prod = $signed(cal_word[2*g]) * $signed({1'b0, adc[g]});
    always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
        cur_ma[g] <= 32'h0000_0000;
      end else begin
        cur_ma[g] <= cal_word[2*g+1] + prod[47:16];
      end
    end
  end

  // apb slave, zero wait states
  assign PREADY_O = 1'b1;
  assign apb_wr   = PSEL_I && PENABLE_I && PWRITE_I;
  assign acc_summary = {21'h0,
                        5'(acc_mem[`ACC_SWITCH_OFS] & `SWITCH_FLAGS_MASK),
                        acc_mem[`ACC_THERM_OFS][3:0] & 4'hF,
                        acc_mem[`ACC_BRAKE_OFS][1:0] & 2'h3};
  always_comb begin
    rd_val    = 32'h0000_0000;
    apb_rd_ok = 1'b1;
    case (PADDR_I)
      `REG_STATUS:      rd_val = {26'h0, MOVE_READY_O, MOTOR_POWER_O, BRAKE_ENGAGE_O, err_flags};
      `REG_BRK_T12:     rd_val = {brake_cfg.t2, brake_cfg.t1};
      `REG_BRK_T34:     rd_val = {brake_cfg.t4, brake_cfg.t3};
      `REG_BRK_FLAGS:   rd_val = {24'h0, brake_cfg.flags};
      `REG_ACC_INDEX:   rd_val = {25'h0, acc_index};
      `REG_ACC_DATA:    rd_val = (acc_index < 7'(`ACC_BYTES)) ? {24'h0, acc_mem[acc_index]} : 32'h0;
      `REG_ACC_SUMMARY: rd_val = acc_summary;
      default: begin
        if (PADDR_I >= `REG_CAL0 && PADDR_I <= `REG_CAL5 && PADDR_I[1:0] == 2'h0) begin
          rd_val = cal_word[3'((PADDR_I - `REG_CAL0) >> 2)];
        end else if (PADDR_I >= `REG_CUR0 && PADDR_I <= `REG_CUR2 && PADDR_I[1:0] == 2'h0) begin
          rd_val = cur_ma[2'((PADDR_I - `REG_CUR0) >> 2)];
        end else begin
          apb_rd_ok = 1'b0;
        end
      end
    endcase
  end
  assign PSLVERR_O = PSEL_I && PENABLE_I && !apb_rd_ok;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= rd_val;
    end
  end
  // data outputs come from flops, so read data is sampled in the setup cycle

  // software-visible configuration; link writes win over apb
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      brake_cfg <= '0;
      acc_index <= 7'h00;
      for (int i = 0; i < 6; i++) begin
        cal_word[i] <= 32'h0000_0000;
      end
    end else begin
      if (apb_wr && apb_rd_ok) begin
        case (PADDR_I)
          `REG_BRK_T12: {brake_cfg.t2, brake_cfg.t1} <= PWDATA_I;
          `REG_BRK_T34: {brake_cfg.t4, brake_cfg.t3} <= PWDATA_I;
          `REG_BRK_FLAGS: brake_cfg.flags <= PWDATA_I[7:0] & `BRK_FLAGS_MASK;
          `REG_ACC_INDEX: acc_index <= PWDATA_I[6:0];
          `REG_ACC_DATA: acc_index <= acc_index + 7'h01;
          default: begin
            if (PADDR_I >= `REG_CAL0 && PADDR_I <= `REG_CAL5) begin
              cal_word[3'((PADDR_I - `REG_CAL0) >> 2)] <= PWDATA_I;
            end
          end
        endcase
      end
      if (link_apply) begin
        brake_cfg <= link_cfg;
      end
    end
  end

  // accessory store image; loaded by software from the eeprom at boot
  always_ff @(posedge REF_CLK_I) begin
    if (apb_wr && PADDR_I == `REG_ACC_DATA && acc_index < 7'(`ACC_BYTES)) begin
      acc_mem[acc_index] <= PWDATA_I[7:0];
    end
  end

  // sticky errors, write one to clear; a new error wins over the clear
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      err_flags <= '0;
    end else begin
      err_flags <= (err_flags & ~((apb_wr && PADDR_I == `REG_STATUS) ? PWDATA_I[2:0] : 3'h0))
                   | err_set;
    end
  end

  // range check of a brake write frame
  always_comb begin
    fixed_cfg = {wbuf[8], wbuf[7], wbuf[6], wbuf[5], wbuf[4], wbuf[3], wbuf[2], wbuf[1],
                 wbuf[0]};
    value_bad = |(fixed_cfg.flags & ~`BRK_FLAGS_MASK);
    fixed_cfg.flags = fixed_cfg.flags & `BRK_FLAGS_MASK;
    if (fixed_cfg.t1 > `BRK_MAX_DELAY) begin
      fixed_cfg.t1 = `BRK_MAX_DELAY;
      value_bad    = 1'b1;
    end
    if (fixed_cfg.t2 > `BRK_MAX_DELAY) begin
      fixed_cfg.t2 = `BRK_MAX_DELAY;
      value_bad    = 1'b1;
    end
    if (fixed_cfg.t3 > `BRK_MAX_DELAY) begin
      fixed_cfg.t3 = `BRK_MAX_DELAY;
      value_bad    = 1'b1;
    end
    if (fixed_cfg.t4 > `BRK_MAX_DELAY) begin
      fixed_cfg.t4 = `BRK_MAX_DELAY;
      value_bad    = 1'b1;
    end
  end

  // receive side: framing, decode, timeout
  assign RX_READY_O = (rx_state != motion_cmd_pkg::RX_REPLY);
  assign rx_take    = RX_VALID_I && RX_READY_O;
  assign full_word  = {RX_DATA_I, cmd_word[23:0]};
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rx_state   <= motion_cmd_pkg::RX_CMD;
      rep_kind   <= motion_cmd_pkg::REP_ZERO;
      rx_cnt     <= 8'h00;
      cmd_word   <= 32'h0000_0000;
      rx_crc     <= `CRC_INIT;
      idle_cnt   <= 32'h0000_0000;
      rep_go     <= 1'b0;
      err_set    <= '0;
      link_apply <= 1'b0;
      link_cfg   <= '0;
    end else begin
      rep_go     <= 1'b0;
      err_set    <= '0;
      link_apply <= 1'b0;
      idle_cnt   <= rx_take ? 32'h0000_0000 : idle_cnt + 32'h0000_0001;
      case (rx_state)
        motion_cmd_pkg::RX_CMD: begin
          if (rx_take) begin
            cmd_word[8*rx_cnt[1:0] +: 8] <= RX_DATA_I;
            rx_cnt <= rx_cnt + 8'h01;
            if (rx_cnt == 8'h00 && RX_DATA_I == 8'h00) begin
              rep_kind <= motion_cmd_pkg::REP_ZERO;
              rep_go   <= 1'b1;
              rx_state <= motion_cmd_pkg::RX_REPLY;
            end else if (rx_cnt == 8'h03) begin
              rx_cnt <= 8'h00;
              rx_crc <= `CRC_INIT;
              rep_go <= 1'b1;
              rx_state <= motion_cmd_pkg::RX_REPLY;
              case (full_word)
                `CODE_READ_ACC: rep_kind <= motion_cmd_pkg::REP_ACC;
                `CODE_READ_BRK: rep_kind <= motion_cmd_pkg::REP_BRK;
                `CODE_READ_CAL: rep_kind <= motion_cmd_pkg::REP_CAL;
                `CODE_WRITE_BRK: begin
                  rep_go   <= 1'b0;
                  rx_state <= motion_cmd_pkg::RX_DATA;
                end
                default: begin
                  rep_kind        <= motion_cmd_pkg::REP_ERRC;
                  err_set.cmd_err <= 1'b1;
                end
              endcase
            end
          end else if (rx_cnt != 8'h00 && idle_cnt >= 32'(RX_TIMEOUT_CYCLES - 1)) begin
            rx_cnt <= 8'h00;
          end
        end
        motion_cmd_pkg::RX_DATA: begin
          if (rx_take) begin
            wbuf[rx_cnt[4:0]] <= RX_DATA_I;
            rx_cnt <= rx_cnt + 8'h01;
            if (rx_cnt < `WBRK_DATA_BYTES) begin
              rx_crc <= crc_step(rx_crc, RX_DATA_I);
            end
            if (rx_cnt == `WBRK_LAST) begin
              rx_cnt   <= 8'h00;
              rep_go   <= 1'b1;
              rx_state <= motion_cmd_pkg::RX_REPLY;
              if ({RX_DATA_I, wbuf[19]} != rx_crc) begin
                rep_kind         <= motion_cmd_pkg::REP_ERRD;
                err_set.data_err <= 1'b1;
              end else begin
                link_cfg   <= fixed_cfg;
                link_apply <= 1'b1;
                rep_kind   <= value_bad ? motion_cmd_pkg::REP_ERRV
                                        : motion_cmd_pkg::REP_ECHO;
                err_set.value_err <= value_bad;
              end
            end
          end else if (idle_cnt >= 32'(RX_TIMEOUT_CYCLES - 1)) begin
            rx_cnt   <= 8'h00;
            rx_state <= motion_cmd_pkg::RX_CMD;
          end
        end
        motion_cmd_pkg::RX_REPLY: begin
          if (tx_done && !rep_go) begin
            rx_state <= motion_cmd_pkg::RX_CMD;
            rx_cnt   <= 8'h00;
          end
        end
        default: rx_state <= motion_cmd_pkg::RX_CMD;
      endcase
    end
  end

  // transmit side: byte of the answer at tx_idx
  assign cal_flat = {cal_word[5], cal_word[4], cal_word[3], cal_word[2], cal_word[1],
                     cal_word[0]};
  assign d_idx    = tx_idx - 8'h04;
  always_comb begin
    rep_len  = `LEN_CODE;
    rep_word = cmd_word;
    case (rep_kind)
      motion_cmd_pkg::REP_ZERO: rep_len = `LEN_ZERO;
      motion_cmd_pkg::REP_ERRC: rep_word = `CODE_ERR_CMD;
      motion_cmd_pkg::REP_ERRD: rep_word = `CODE_ERR_DATA;
      motion_cmd_pkg::REP_ERRV: rep_word = `CODE_ERR_VALUE;
      motion_cmd_pkg::REP_ACC:  rep_len  = `LEN_ACC;
      motion_cmd_pkg::REP_BRK:  rep_len  = `LEN_BRK;
      motion_cmd_pkg::REP_CAL:  rep_len  = `LEN_CAL;
      default: rep_len = `LEN_CODE;
    endcase
    next_is_data = (tx_idx >= `LEN_CODE) && (tx_idx < rep_len - 8'h02);
    if (rep_kind == motion_cmd_pkg::REP_ZERO) begin
      next_byte = 8'h00;
    end else if (tx_idx < `LEN_CODE) begin
      next_byte = rep_word[8*tx_idx[1:0] +: 8];
    end else if (tx_idx == rep_len - 8'h02) begin
      next_byte = tx_crc[7:0];
    end else if (tx_idx == rep_len - 8'h01) begin
      next_byte = tx_crc[15:8];
    end else if (rep_kind == motion_cmd_pkg::REP_ACC) begin
      next_byte = acc_mem[d_idx[6:0]];
    end else if (rep_kind == motion_cmd_pkg::REP_BRK) begin
      next_byte = (d_idx < `BRK_CFG_BYTES) ? brake_cfg[8*d_idx[3:0] +: 8] : 8'h00;
    end else begin
      next_byte = (d_idx < `CAL_COEF_BYTES) ? cal_flat[8*d_idx[4:0] +: 8] : 8'h00;
    end
  end
  assign tx_step = tx_busy && (!TX_VALID_O || TX_READY_I);
  assign tx_done = tx_step && (tx_idx == rep_len);
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      tx_busy    <= 1'b0;
      tx_idx     <= 8'h00;
      tx_crc     <= `CRC_INIT;
      TX_VALID_O <= 1'b0;
      TX_DATA_O  <= 8'h00;
    end else if (rep_go) begin
      tx_busy <= 1'b1;
      tx_idx  <= 8'h00;
      tx_crc  <= `CRC_INIT;
    end else begin
      if (TX_VALID_O && TX_READY_I) begin
        TX_VALID_O <= 1'b0;
      end
      if (tx_step) begin
        if (tx_idx < rep_len) begin
          TX_VALID_O <= 1'b1;
          TX_DATA_O  <= next_byte;
          tx_idx     <= tx_idx + 8'h01;
          if (next_is_data) begin
            tx_crc <= crc_step(tx_crc, next_byte);
          end
        end else begin
          tx_busy <= 1'b0;
        end
      end
    end
  end

  // brake sequencer with millisecond timer
  assign brk_en  = brake_cfg.flags[`BRK_ENABLE_BIT];
  assign expired = (ms_cnt >= wait_ms);
  always_comb begin
    case (br_state)
      motion_cmd_pkg::BR_PWR_WAIT:  wait_ms = brake_cfg.t1;
      motion_cmd_pkg::BR_REL_WAIT:  wait_ms = brake_cfg.t2;
      motion_cmd_pkg::BR_STOP_WAIT: wait_ms = brake_cfg.t3;
      motion_cmd_pkg::BR_ENG_WAIT:  wait_ms = brake_cfg.t4;
      default: wait_ms = 16'h0000;
    endcase
  end
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      br_state <= motion_cmd_pkg::BR_OFF;
      pre_cnt  <= 32'h0000_0000;
      ms_cnt   <= 16'h0000;
    end else begin
      if (pre_cnt >= 32'(CYCLES_PER_MS - 1)) begin
        pre_cnt <= 32'h0000_0000;
        ms_cnt  <= ms_cnt + 16'h0001;
      end else begin
        pre_cnt <= pre_cnt + 32'h0000_0001;
      end
      case (br_state)
        motion_cmd_pkg::BR_OFF, motion_cmd_pkg::BR_HELD: begin
          if (RUN_REQ_I) begin
            br_state <= brk_en ? motion_cmd_pkg::BR_PWR_WAIT : motion_cmd_pkg::BR_READY;
          end
        end
        motion_cmd_pkg::BR_PWR_WAIT: begin
          if (!RUN_REQ_I) begin
            br_state <= motion_cmd_pkg::BR_OFF;
          end else if (expired) begin
            br_state <= motion_cmd_pkg::BR_REL_WAIT;
          end
        end
        motion_cmd_pkg::BR_REL_WAIT: begin
          if (!RUN_REQ_I) begin
            br_state <= motion_cmd_pkg::BR_STOP_WAIT;
          end else if (expired) begin
            br_state <= motion_cmd_pkg::BR_READY;
          end
        end
        motion_cmd_pkg::BR_READY: begin
          if (!RUN_REQ_I) begin
            br_state <= brk_en ? motion_cmd_pkg::BR_STOP_WAIT : motion_cmd_pkg::BR_OFF;
          end
        end
        motion_cmd_pkg::BR_STOP_WAIT: begin
          if (expired) begin
            br_state <= motion_cmd_pkg::BR_ENG_WAIT;
          end
        end
        motion_cmd_pkg::BR_ENG_WAIT: begin
          if (expired) begin
            br_state <= brake_cfg.flags[`BRK_CUTS_BIT] ? motion_cmd_pkg::BR_OFF
                                                       : motion_cmd_pkg::BR_HELD;
          end
        end
        default: br_state <= motion_cmd_pkg::BR_OFF;
      endcase
      // restart the timer when a wait expires and while off, ready or held; a stop during the release wait carries its count into the stop wait
      if (br_state != motion_cmd_pkg::BR_OFF && br_state != motion_cmd_pkg::BR_READY
          && br_state != motion_cmd_pkg::BR_HELD && expired) begin
        pre_cnt <= 32'h0000_0000;
        ms_cnt  <= 16'h0000;
      end else if ((br_state == motion_cmd_pkg::BR_OFF || br_state == motion_cmd_pkg::BR_HELD
                    || br_state == motion_cmd_pkg::BR_READY)) begin
        pre_cnt <= 32'h0000_0000;
        ms_cnt  <= 16'h0000;
      end
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      MOTOR_POWER_O  <= 1'b0;
      BRAKE_ENGAGE_O <= 1'b0;
      MOVE_READY_O   <= 1'b0;
    end else begin
      MOTOR_POWER_O  <= (br_state != motion_cmd_pkg::BR_OFF);
      BRAKE_ENGAGE_O <= brk_en && (br_state == motion_cmd_pkg::BR_OFF
                        || br_state == motion_cmd_pkg::BR_PWR_WAIT
                        || br_state == motion_cmd_pkg::BR_ENG_WAIT
                        || br_state == motion_cmd_pkg::BR_HELD);
      MOVE_READY_O   <= (br_state == motion_cmd_pkg::BR_READY);
    end
  end
  assign MOVE_GO_O = MOVE_REQ_I && MOVE_READY_O;
endmodule : motion_cmd_responder
`default_nettype wire

// ---- tb/host_link_model.sv ----
// host reader: takes answer bytes, stalling now and then
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  input  wire logic       clk_i, rst_i, valid_i,
  input  wire logic [7:0] data_i,
  output logic            ready_o
);
  logic [7:0] got [$];
  logic [2:0] cnt = 3'h0;
  always @(posedge clk_i) begin
    cnt <= cnt + 3'h1;
    ready_o <= (cnt != 3'h2); // a slow reader exposes byte holding
    if (!rst_i && valid_i && ready_o === 1'b1) got.push_back(data_i);
  end
endmodule : host_link_model
`default_nettype wire

// ---- tb/motion_cmd_assertions.sv ----
// port checker of the command responder
`timescale 1ns/1ps
`default_nettype none
module motion_cmd_checker (
  input wire logic       REF_CLK_I, RST_I, PSEL_I, PENABLE_I, PSLVERR_O, RX_READY_O,
  input wire logic       TX_VALID_O, TX_READY_I, RUN_REQ_I, MOVE_REQ_I, MOVE_GO_O,
  input wire logic       MOVE_READY_O, MOTOR_POWER_O, BRAKE_ENGAGE_O,
  input wire logic [7:0] TX_DATA_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_stall; TX_VALID_O && !TX_READY_I; endsequence
  sequence s_held; TX_VALID_O && $stable(TX_DATA_O); endsequence
  a_tx_hold: assert property (s_stall |=> s_held)
    else $error("answer byte lost while stalled");
  a_tx_quiet: assert property (TX_VALID_O |-> !RX_READY_O)
    else $error("receive open during answer");
  a_rx_resume: assert property ($fell(TX_VALID_O) |-> ##[0:2] RX_READY_O)
    else $error("receive not reopened");
  a_go_gate: assert property (MOVE_GO_O == (MOVE_REQ_I && MOVE_READY_O))
    else $error("motion passed while not ready");
  a_ready_free: assert property (MOVE_READY_O |-> MOTOR_POWER_O && !BRAKE_ENGAGE_O)
    else $error("ready with brake on or no power");
  a_run_drop: assert property (!RUN_REQ_I |-> ##[0:2] !MOVE_READY_O)
    else $error("ready kept after stop");
  a_ready_cause: assert property ($rose(MOVE_READY_O) |-> $past(RUN_REQ_I, 2))
    else $error("ready without run request");
  a_err_phase: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
    else $error("bus error outside access");
endmodule : motion_cmd_checker
bind motion_cmd_responder motion_cmd_checker chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PSLVERR_O(PSLVERR_O), .RX_READY_O(RX_READY_O),
  .TX_VALID_O(TX_VALID_O), .TX_READY_I(TX_READY_I), .RUN_REQ_I(RUN_REQ_I),
  .MOVE_REQ_I(MOVE_REQ_I), .MOVE_GO_O(MOVE_GO_O), .MOVE_READY_O(MOVE_READY_O),
  .MOTOR_POWER_O(MOTOR_POWER_O), .BRAKE_ENGAGE_O(BRAKE_ENGAGE_O), .TX_DATA_O(TX_DATA_O));
`default_nettype wire

// ---- tb/motion_cmd_responder_bench.sv ----
// bench of the command responder
`timescale 1ns/1ps
`default_nettype none
`include "motion_cmd_defines.svh"
module motion_cmd_responder_bench;
  typedef logic [7:0] bq_t [$];
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rxv = 0, run = 0, mv = 0, qe;
  logic [7:0] pa = 0, rxd = 0, txd;
  logic [31:0] pwd = 0, prd, q;
  logic [15:0] adc = 16'h0100;
  logic prdy, perr, rdy, txv, txr, go, mrdy, pon, brk;
  int n_errors = 0, check_count = 0, n;
  bq_t d;
  motion_cmd_responder #(.CYCLES_PER_MS(10), .RX_TIMEOUT_CYCLES(200)) uut (
    .REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .RX_VALID_I(rxv), .RX_DATA_I(rxd), .RX_READY_O(rdy), .TX_VALID_O(txv),
    .TX_DATA_O(txd), .TX_READY_I(txr), .RUN_REQ_I(run), .MOVE_REQ_I(mv),
    .MOVE_GO_O(go), .MOVE_READY_O(mrdy), .MOTOR_POWER_O(pon), .BRAKE_ENGAGE_O(brk),
    .ADC_WIND1_I(adc), .ADC_WIND2_I(adc), .ADC_TOTAL_I(adc));
  host_link_model host (.clk_i(clk), .rst_i(rst), .valid_i(txv), .data_i(txd), .ready_o(txr));
  initial forever #5 clk = ~clk;
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] s, x);
    check_count++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= v;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    q = prd;
    qe = perr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  task automatic snd(input bq_t b);
    foreach (b[i]) begin
      @(posedge clk);
      rxv <= 1;
      rxd <= b[i];
      do @(posedge clk); while (rdy !== 1'b1);
      rxv <= 0;
    end
  endtask : snd
  function automatic bq_t le(input logic [31:0] c);
    return {c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction : le
  function automatic bq_t crc(input bq_t b);
    logic [15:0] c;
    c = `CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
    end
    return {c[7:0], c[15:8]};
  endfunction : crc
  // whole answer compared, length included, so a short or long reply shows
  task automatic xfer(input bq_t r, e);
    int i;
    snd(r);
    for (i = 0; i < 3000 && host.got.size() < e.size(); i++) @(posedge clk);
    repeat (6) @(posedge clk);
    chk(32'(host.got.size()), 32'(e.size()));
    foreach (e[k]) if (k < host.got.size()) chk(host.got[k], e[k]);
    host.got.delete();
    $display("test ended at %0t", $time);
  endtask : xfer
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    apb(1, `REG_BRK_FLAGS, 32'hFF);
    apb(0, `REG_BRK_FLAGS, 0);
    chk(q, 32'h3);
    apb(0, 8'h40, 0);
    chk(q + 32'(qe), 32'h1);
    xfer(le(32'h11223344), le(`CODE_ERR_CMD));
    apb(0, `REG_STATUS, 0);
    chk(q & 32'h7, 32'h1);
    apb(1, `REG_STATUS, 32'h7);
    xfer({8'h00}, {8'h00});
    apb(1, `REG_BRK_T12, 32'h0003_0002);
    apb(1, `REG_BRK_T34, 32'h0002_0002);
    d = {8'h02, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 8'h03};
    repeat (10) d.push_back(8'h00);
    xfer(le(`CODE_READ_BRK), {le(`CODE_READ_BRK), d, crc(d)});
    xfer({le(`CODE_WRITE_BRK), d, crc({8'h01})}, le(`CODE_ERR_DATA));
    d[1] = 8'hFF;
    xfer({le(`CODE_WRITE_BRK), d, crc(d)}, le(`CODE_ERR_VALUE));
    apb(0, `REG_STATUS, 0);
    chk(q & 32'h7, 32'h6);
    apb(0, `REG_BRK_T12, 0);
    chk(q, {16'h0003, `BRK_MAX_DELAY});
    d[1] = 8'h00;
    xfer({le(`CODE_WRITE_BRK), d, crc(d)}, le(`CODE_WRITE_BRK));
    apb(0, `REG_BRK_T12, 0);
    chk(q, 32'h0003_0002);
    snd({8'h67, 8'h62});
    repeat (250) @(posedge clk);
    xfer({8'h00}, {8'h00});
    apb(1, `REG_ACC_INDEX, 0);
    d = {};
    for (n = 0; n < 108; n++) begin
      apb(1, `REG_ACC_DATA, n);
      d.push_back(n[7:0]);
    end
    apb(0, `REG_ACC_SUMMARY, 0);
    chk(q, 32'h430);
    xfer(le(`CODE_READ_ACC), {le(`CODE_READ_ACC), d, crc(d)});
    d = {};
    for (n = 0; n < 6; n++) begin
      q = (n == 0) ? 32'h0002_0000 : (n == 1) ? 32'h5 : 32'h0;
      d = {d, le(q)};
      apb(1, `REG_CAL0 + 8'(4 * n), q);
    end
    repeat (88) d.push_back(8'h00);
    xfer(le(`CODE_READ_CAL), {le(`CODE_READ_CAL), d, crc(d)});
    apb(0, `REG_CUR0, 0);
    chk(q, 32'h205);
    run <= 1;
    repeat (8) @(posedge clk);
    chk({29'h0, pon, brk, mrdy}, 32'h6);
    for (n = 8; n < 200 && mrdy !== 1'b1; n++) @(posedge clk);
    chk({mrdy, n >= 40}, 2'b11);
    mv <= 1;
    repeat (2) @(posedge clk);
    chk(go, 1'b1);
    run <= 0;
    repeat (8) @(posedge clk);
    chk({28'h0, pon, brk, mrdy, go}, 32'h8);
    for (n = 8; n < 200 && pon !== 1'b0; n++) @(posedge clk);
    chk({brk, n >= 25}, 2'b11);
    apb(1, `REG_BRK_FLAGS, 32'h1);
    run <= 1;
    repeat (80) @(posedge clk);
    run <= 0;
    repeat (80) @(posedge clk);
    chk({pon, brk, mrdy}, 3'b110);
    summarize();
  end
  initial begin
    #100us;
    n_errors++;
    summarize();
  end
endmodule : motion_cmd_responder_bench
`default_nettype wire
